// File: dv/tso_output_sva.sv
/* tso_output_sva: port assertions for the stream output port.
   assumes binding to tso_output, one clock, sync active-low reset. */
`timescale 1ns/1ps
module tso_output_sva
    import tso_pkg::*;
(
    input wire logic               clk_sys,
    input wire logic               rst_n,
    input wire logic               sym_clk_en,
    input wire logic               sym_lock,
    input wire logic               stream_output_disable,
    input wire logic               stream_output_clock,
    input wire tso_pkg::tso_pins_t pins_o,
    input wire logic               pins_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [2:0] since_r;
    // cycles since the output clock last moved; pins may only follow a clock edge
    always_ff @(posedge clk_sys) begin
        if (!rst_n) since_r <= 3'h7;
        else if ($changed(stream_output_clock)) since_r <= 3'h0;
        else if (since_r != 3'h7) since_r <= since_r + 3'h1;
    end
    sequence pkt_open;
        $rose(pins_o.valid);
    endsequence
    oe_follow_a: assert property (pins_oe == !stream_output_disable) else $error("oe wrong");
    gap_low_a: assert property (!pins_o.valid |-> pins_o.data == 8'h00) else $error("gap data");
    start_in_pkt_a: assert property (pins_o.start |-> pins_o.valid) else $error("stray start");
    pkt_open_a: assert property (pkt_open |-> pins_o.start) else $error("no start");
    start_once_a: assert property ($past(pins_o.start) && $changed(pins_o.data) |-> !pins_o.start)
        else $error("long start");
    err_in_pkt_a: assert property (!pins_o.blk_err_n |-> pins_o.valid) else $error("err gap");
    err_steady_a: assert property (pins_o.valid && $past(pins_o.valid) |-> $stable(pins_o.blk_err_n))
        else $error("err moved");
    clk_run_a: assert property (sym_clk_en && sym_lock |=> $changed(stream_output_clock))
        else $error("clock stuck");
    clk_hold_a: assert property (!sym_lock |=> $stable(stream_output_clock)) else $error("clk ran");
    pin_edge_a: assert property ($changed(pins_o) |-> since_r <= 3'h3) else $error("pin off edge");
endmodule

// File: dv/tso_output_tb.sv
/* tso_output_tb: self-checking bench for the stream output port.
   assumes tso_sink captures bytes; packets modelled in queues here. */
`timescale 1ns/1ps
module tso_output_tb;
    import tso_pkg::*;
    logic      clk_sys = 1'b0, rst_n = 1'b0, sym_clk_en = 1'b0, sym_lock = 1'b1, inv = 1'b1;
    logic      in_valid = 1'b0, reg_wr = 1'b0, stream_output_disable = 1'b1;
    logic      in_ready, stream_output_clock, pins_oe, packet_active;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    tso_beat_t in_beat = '0;
    tso_beat_t beats[$];
    tso_pins_t pins_o;
    int        n_mismatch = 0, comparisons = 0;
    bit [3:0]  cfg[6] = '{4'b1010, 4'b1110, 4'b1100, 4'b1101, 4'b0011, 4'b0110};
    always #12.5 clk_sys = ~clk_sys;
    tso_output u_dut(.clk_sys(clk_sys), .rst_n(rst_n), .sym_clk_en(sym_clk_en),
        .sym_lock(sym_lock), .in_beat(in_beat), .in_valid(in_valid), .in_ready(in_ready),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .stream_output_disable(stream_output_disable),
        .stream_output_clock(stream_output_clock), .pins_o(pins_o), .pins_oe(pins_oe),
        .packet_active(packet_active));
    tso_sink u_sink(.clk_line(stream_output_clock), .inv(inv), .pins(pins_o));
    always @(posedge clk_sys) if (in_valid && in_ready) void'(beats.pop_front());
    always @(negedge clk_sys) begin
        sym_clk_en <= ~sym_clk_en;
        in_valid <= beats.size() > 0;
        if (beats.size() > 0) in_beat <= beats[0];
    end
    task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        reg_addr = a;
        #1 chk("reg", {3'h0, e}, {3'h0, reg_rdata});
    endtask
    task automatic pkt(input bit bad, input bit en, input bit transport_error_indicator);
        logic [10:0] exp[$];
        tso_beat_t   b;
        u_sink.q.delete();
        // a stray beat ahead of the packet must be dropped, not sent
        b = '0;
        b.data = 8'($urandom);
        beats.push_back(b);
        for (int i = 0; i < TSO_PKT_LEN; i++) begin
            b.data = 8'($urandom);
            if (i == TSO_TEI_BYTE) b.data[TSO_TEI_BIT] = transport_error_indicator;
            b.first = (i == 0);
            b.last = (i == TSO_PKT_LEN - 1);
            b.uncorr = bad && (i == 0);
            beats.push_back(b);
            if (i == TSO_TEI_BYTE && bad && en) b.data[TSO_TEI_BIT] = 1'b1;
            exp.push_back({b.data, i == 0, 1'b1, !bad});
        end
        for (int k = 0; k < 400 && u_sink.q.size() == 0; k++) @(negedge clk_sys);
        chk("active", 11'd1, {10'h0, packet_active});
        for (int k = 0; k < 2000 && u_sink.q.size() < TSO_PKT_LEN; k++) @(posedge clk_sys);
        repeat (20) @(negedge clk_sys);
        chk("idle", 11'd0, {10'h0, packet_active});
        chk("count", 11'd188, 11'(u_sink.q.size()));
        for (int i = 0; i < TSO_PKT_LEN; i++) chk("byte", exp[i], u_sink.q[i]);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #500000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h79998458));
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        rd(TSO_POLARITY_OFS, 8'h01);
        rd(TSO_CLKCTL_OFS, 8'h01);
        rd(8'h33, 8'h00);
        for (int t = 0; t < 6; t++) begin
            wr(TSO_POLARITY_OFS, {7'h0, cfg[t][3]});
            wr(TSO_CLKCTL_OFS, {7'h0, cfg[t][1]});
            rd(TSO_CLKCTL_OFS, {7'h0, cfg[t][1]});
            inv = cfg[t][3];
            sym_lock = 1'b0;
            stream_output_disable = 1'($urandom);
            repeat (10) @(negedge clk_sys);
            sym_lock = 1'b1;
            stream_output_disable = 1'b0;
            pkt(cfg[t][2], cfg[t][1], cfg[t][0]);
            $display("test %0d done", t);
        end
        wrap_up();
    end
endmodule
bind tso_output tso_output_sva u_sva(.clk_sys(clk_sys), .rst_n(rst_n), .sym_clk_en(sym_clk_en),
    .sym_lock(sym_lock), .stream_output_disable(stream_output_disable),
    .stream_output_clock(stream_output_clock), .pins_o(pins_o), .pins_oe(pins_oe));

// File: dv/tso_sink.sv
/* tso_sink: behavioural stream receiver capturing valid bytes.
   assumes pins settle on the opposite edge to the sampling one. */
`timescale 1ns/1ps
module tso_sink
    import tso_pkg::*;
(
    input wire logic               clk_line,
    input wire logic               inv,
    input wire tso_pkg::tso_pins_t pins
);
    logic [10:0] q[$];
    always @(clk_line) begin
        if (clk_line === inv && pins.valid === 1'b1) q.push_back(pins);
    end
endmodule

// File: rtl/tso_fifo.sv
/*
 * tso_fifo: small synchronous fifo with valid/ready on both sides.
 * Assumes one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
module tso_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // full at DEPTH entries; an empty fifo must accept
    assign in_ready  = (cnt_r < (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// File: rtl/tso_output.sv
/*
 * tso_output: parallel transport stream output port.
 * Assumes decoded bytes arrive from the decoder with first/last/uncorrectable
 * marks, a one-cycle symbol clock enable, a symbol lock level, and a simple
 * 8-bit register write/read port from the serial host interface.
 */
`timescale 1ns/1ps
module tso_output
    import tso_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             sym_clk_en,
    input  wire logic             sym_lock,
    input  wire tso_pkg::tso_beat_t in_beat,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    output logic      [7:0]       reg_rdata,
    input  wire logic             stream_output_disable,
    output logic                  stream_output_clock,
    output tso_pkg::tso_pins_t    pins_o,
    output logic                  pins_oe,
    output logic                  packet_active
);
    import tso_pkg::*;

    typedef enum logic [1:0] {TSO_IDLE, TSO_SEND} tso_state_t;

    logic [7:0]  polarity_r;
    logic [7:0]  clkctl_r;
    logic        clk_r;
    logic        out_edge_r;
    tso_state_t  state_r;
    tso_state_t  state_nxt;
    logic [7:0]  idx_r;
    logic        bad_r;
    tso_pins_t   pins_r;
    tso_beat_t   fifo_beat;
    logic        fifo_valid;
    logic        fifo_ready;

    // register decode; the host port sequences the pointer itself
    wire         wr_pol  = reg_wr && (reg_addr == TSO_POLARITY_OFS);
    wire         wr_ctl  = reg_wr && (reg_addr == TSO_CLKCTL_OFS);
    wire         invert  = polarity_r[TSO_INVERT_BIT];
    wire         err_en  = clkctl_r[TSO_ERR_EN_BIT];

    assign reg_rdata = (reg_addr == TSO_POLARITY_OFS) ? polarity_r :
                       (reg_addr == TSO_CLKCTL_OFS)   ? clkctl_r   : 8'h00;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            polarity_r <= TSO_POLARITY_RST;
            clkctl_r   <= TSO_CLKCTL_RST;
        end else begin
            if (wr_pol) begin
                polarity_r <= reg_wdata;
            end
            if (wr_ctl) begin
                clkctl_r <= reg_wdata;
            end
        end
    end

    // output clock toggles on each symbol enable while locked; holds its level when lock drops
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            clk_r      <= 1'b0;
            out_edge_r <= 1'b0;
        end else begin
            out_edge_r <= 1'b0;
            if (sym_clk_en && sym_lock) begin
                clk_r      <= ~clk_r;
                // data changes on the edge opposite to the sampling edge
                out_edge_r <= invert ? clk_r : ~clk_r;
            end
        end
    end

    // one clk_sys cycle after the chosen edge the pins show the new beat
    wire byte_tick = out_edge_r;

    tso_fifo #(
        .WIDTH ($bits(tso_beat_t)),
        .DEPTH (TSO_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_data   (in_beat),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .out_data  (fifo_beat),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready)
    );

    // a packet is only started when its first byte is ready; later bytes must
    // keep up with the output clock, the decoder is assumed to deliver in time
    wire start_ok = fifo_valid && fifo_beat.first;
    wire last_byte = (idx_r == 8'(TSO_PKT_LEN - 1));
    // the tick after the last byte is the gap, so a packet never runs to 189 bytes
    wire send_byte = byte_tick && ((state_r == TSO_SEND && !last_byte) ||
                                   (state_r == TSO_IDLE && start_ok));
    // stray bytes outside a packet are dropped so the next start stays aligned
    assign fifo_ready = send_byte || (byte_tick && state_r == TSO_IDLE && fifo_valid);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TSO_IDLE: begin
                if (byte_tick && start_ok) begin
                    state_nxt = TSO_SEND;
                end
            end
            TSO_SEND: begin
                if (byte_tick && last_byte) begin
                    state_nxt = TSO_IDLE;
                end
            end
            default: state_nxt = TSO_IDLE;
        endcase
    end

    // error indicator: forced for uncorrectable packets when enabled, otherwise passed as received
    wire is_tei_byte = (idx_r == 8'(TSO_TEI_BYTE - 1)) && (state_r == TSO_SEND);
    wire bad_pkt     = (state_r == TSO_IDLE) ? fifo_beat.uncorr : (bad_r | fifo_beat.uncorr);
    logic [7:0] out_byte;
    always_comb begin
        out_byte = fifo_beat.data;
        if (is_tei_byte && err_en && bad_pkt) begin
            out_byte[TSO_TEI_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= TSO_IDLE;
            idx_r   <= 8'h00;
            bad_r   <= 1'b0;
            pins_r  <= '{data: 8'h00, start: 1'b0, valid: 1'b0, blk_err_n: 1'b1};
        end else begin
            state_r <= state_nxt;
            if (byte_tick) begin
                if (send_byte) begin
                    // bytes follow back to back: no gap inside a packet
                    idx_r  <= (state_r == TSO_IDLE) ? 8'h00 : idx_r + 8'h01;
                    bad_r  <= bad_pkt;
                    pins_r.data      <= out_byte;
                    pins_r.start     <= (state_r == TSO_IDLE);
                    pins_r.valid     <= 1'b1;
                    pins_r.blk_err_n <= ~bad_pkt;
                end else begin
                    pins_r <= '{data: 8'h00, start: 1'b0, valid: 1'b0, blk_err_n: 1'b1};
                    bad_r  <= 1'b0;
                end
            end
        end
    end

    assign stream_output_clock = clk_r;
    assign pins_o        = pins_r;
    assign pins_oe       = ~stream_output_disable;
    assign packet_active = (state_r == TSO_SEND);
endmodule

// File: rtl/tso_pkg.sv
/*
 * tso_pkg: constants, register layout and carrier types for the transport
 * stream output port. Assumes one system clock; everything else is derived.
 */
package tso_pkg;
    localparam logic [7:0] TSO_POLARITY_OFS    = 8'h50;
    localparam logic [7:0] TSO_CLKCTL_OFS      = 8'h77;
    localparam int         TSO_INVERT_BIT      = 0;
    localparam int         TSO_ERR_EN_BIT      = 0;
    localparam logic [7:0] TSO_POLARITY_RST    = 8'h01;
    localparam logic [7:0] TSO_CLKCTL_RST      = 8'h01;
    localparam int         TSO_PKT_LEN         = 188;
    localparam int         TSO_TEI_BYTE        = 1;
    localparam int         TSO_TEI_BIT         = 7;
    localparam int         TSO_FIFO_DEPTH      = 4;
    localparam logic [7:0] TSO_SYNC_BYTE       = 8'h47;

    typedef struct packed {
        logic [7:0] data;
        logic       first;
        logic       last;
        logic       uncorr;
    } tso_beat_t;

    typedef struct packed {
        logic [7:0] data;
        logic       start;
        logic       valid;
        logic       blk_err_n;
    } tso_pins_t;
endpackage
